// ===== hdl/pmu_regs_pkg.sv
// Register map, field layout and reset values of the PMU control bank
package pmu_regs_pkg;

  localparam logic [7:0] SYS_MON_OFS = 8'h00;
  localparam logic [7:0] SYS_HIB_OFS = 8'h01;
  localparam logic [7:0] B1_PRI_OFS = 8'h20;
  localparam logic [7:0] B1_SEC_OFS = 8'h21;
  localparam logic [7:0] B1_CTL_OFS = 8'h22;

  // system_monitor_control fields
  localparam int MON_TRST_BIT = 7;
  localparam int MON_RESP_BIT = 6;
  localparam int MON_IEN_BIT = 5;
  localparam int MON_STAT_BIT = 4;
  localparam int MON_THR_LSB = 0;
  // system_hibernate_control fields
  localparam int HIB_FRC_BIT = 6;
  localparam int HIB_RDY_BIT = 1;
  localparam logic [7:0] HIB_SCRATCH_MASK = 8'h0d;
  // buck1_control fields
  localparam int CTL_ON_BIT = 7;
  localparam int CTL_PHASE_BIT = 6;
  localparam int CTL_MODE_BIT = 5;
  localparam int CTL_DLY_LSB = 2;
  localparam int CTL_FIEN_BIT = 1;

  // Reset values; encodings of codes are not given, plain defaults used
  localparam logic [7:0] SYS_MON_RST = 8'h00;
  localparam logic [7:0] SYS_HIB_RST = 8'h00;
  localparam logic [5:0] B1_PRI_RST = 6'h00;
  localparam logic [5:0] B1_SEC_RST = 6'h00;
  localparam logic [7:0] B1_CTL_RST = 8'h00;

  // Writable masks (reserved and read-only bits dropped)
  localparam logic [7:0] SYS_MON_WMASK = 8'hef;
  localparam logic [7:0] SYS_HIB_WMASK = 8'h4f;
  localparam logic [7:0] B1_CTL_WMASK = 8'hfe;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic reset_timeout_sel;
    logic supply_irq;
    logic auto_shutdown;
    logic [3:0] supply_threshold_code;
  } monitor_ctl_s;

  typedef struct packed {
    logic enable;
    logic phase_shift;
    logic forced_pwm;
    logic [2:0] turn_on_delay;
    logic [5:0] voltage_code;
    logic fault_irq;
  } buck_ctl_s;

endpackage

// ===== hdl/pmu_system_and_buck_control_regs.sv
// Control and status register bank for system monitor and buck1
// How it works
// - Bit 7 of reg 0x00 selects reset timeout
// - Response bit: interrupt if 1, shutdown if 0
// - Monitor interrupt off at reset, enable bit
// - Status bit reads live supply-low comparator
// - Four-bit threshold code drives the monitor
// - Force-on keeps buck1 enabled in hibernate
// - Hibernate-ready flag kept for software to read
// - Scratch bits read/write, cleared on shutdown
// - Primary voltage code used when select low
// - Secondary voltage code used when select high
// - Enable bit turns buck1 on and off
// - Phase bit selects 180 degree shifted switching
// - Mode bit selects forced PWM or power save
// - Three-bit turn-on delay field for sequencing
// - Fault interrupt enable gates buck1 fault interrupts
// - Power loss returns all stored bits to defaults; the status bit stays live
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module pmu_system_and_buck_control_regs (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Monitor and system events
  input wire logic supply_low_in,
  input wire logic system_shutdown_in,
  input wire logic hibernate_in,
  input wire logic buck1_fault_in,
  input wire logic voltage_select_pin_in,
  // Monitor outputs
  output logic reset_timeout_sel_out,
  output logic [3:0] supply_threshold_code_out,
  output logic supply_irq_out,
  output logic auto_shutdown_out,
  // Buck1 outputs
  output logic buck1_enable_out,
  output logic buck1_phase_out,
  output logic buck1_forced_pwm_out,
  output logic [2:0] buck1_delay_out,
  output logic [5:0] buck1_vcode_out,
  output logic buck1_fault_irq_out
);

  pmu_regs_pkg::bus_req_s req;
  pmu_regs_pkg::monitor_ctl_s mon;
  pmu_regs_pkg::buck_ctl_s buck;

  logic [7:0] mon_q;
  logic [7:0] hib_q;
  logic [5:0] pri_q;
  logic [5:0] sec_q;
  logic [7:0] ctl_q;
  logic [7:0] mon_d;
  logic [7:0] hib_d;
  logic [5:0] pri_d;
  logic [5:0] sec_d;
  logic [7:0] ctl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] mon_rd;
  logic [7:0] read_mux;

  wire wr_mon;
  wire wr_hib;
  wire wr_pri;
  wire wr_sec;
  wire wr_ctl;
  wire mapped;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // Address decode
  assign wr_mon = req.wr && (req.addr == pmu_regs_pkg::SYS_MON_OFS);
  assign wr_hib = req.wr && (req.addr == pmu_regs_pkg::SYS_HIB_OFS);
  assign wr_pri = req.wr && (req.addr == pmu_regs_pkg::B1_PRI_OFS);
  assign wr_sec = req.wr && (req.addr == pmu_regs_pkg::B1_SEC_OFS);
  assign wr_ctl = req.wr && (req.addr == pmu_regs_pkg::B1_CTL_OFS);
  assign mapped = (req.addr == pmu_regs_pkg::SYS_MON_OFS) ||
                  (req.addr == pmu_regs_pkg::SYS_HIB_OFS) ||
                  (req.addr == pmu_regs_pkg::B1_PRI_OFS) ||
                  (req.addr == pmu_regs_pkg::B1_SEC_OFS) ||
                  (req.addr == pmu_regs_pkg::B1_CTL_OFS);

  // Only writable bits take the write
  assign mon_d = wr_mon ? (req.wdata & pmu_regs_pkg::SYS_MON_WMASK)
                        : mon_q;
  assign pri_d = wr_pri ? req.wdata[5:0] : pri_q;
  assign sec_d = wr_sec ? req.wdata[5:0] : sec_q;
  assign ctl_d = wr_ctl ? (req.wdata & pmu_regs_pkg::B1_CTL_WMASK)
                        : ctl_q;

  // Shutdown clears scratch; force-on and ready flag survive it
  always_comb begin
    hib_d = wr_hib ? (req.wdata & pmu_regs_pkg::SYS_HIB_WMASK) : hib_q;
    if (system_shutdown_in) begin
      hib_d = hib_d & ~pmu_regs_pkg::HIB_SCRATCH_MASK;
    end
  end

  // Status bit is live, never stored
  always_comb begin
    mon_rd = mon_q;
    mon_rd[pmu_regs_pkg::MON_STAT_BIT] = supply_low_in;
  end

  // Reserved bits of the voltage registers read as zero
  assign read_mux =
    (req.addr == pmu_regs_pkg::SYS_MON_OFS) ? mon_rd :
    (req.addr == pmu_regs_pkg::SYS_HIB_OFS) ? hib_q :
    (req.addr == pmu_regs_pkg::B1_PRI_OFS) ? {2'h0, pri_q} :
    (req.addr == pmu_regs_pkg::B1_SEC_OFS) ? {2'h0, sec_q} :
    (req.addr == pmu_regs_pkg::B1_CTL_OFS) ? ctl_q : 8'h00;
  assign rdata_d = (req.rd && mapped) ? read_mux : 8'h00;

  // Reset stands for loss of input power or lockout
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      mon_q <= pmu_regs_pkg::SYS_MON_RST;
      hib_q <= pmu_regs_pkg::SYS_HIB_RST;
      pri_q <= pmu_regs_pkg::B1_PRI_RST;
      sec_q <= pmu_regs_pkg::B1_SEC_RST;
      ctl_q <= pmu_regs_pkg::B1_CTL_RST;
      rdata_q <= 8'h00;
    end else begin
      mon_q <= mon_d;
      hib_q <= hib_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

  // Monitor controls
  assign mon.reset_timeout_sel = mon_q[pmu_regs_pkg::MON_TRST_BIT];
  assign mon.supply_threshold_code =
    mon_q[pmu_regs_pkg::MON_THR_LSB +: 4];
  // Interrupt only in interrupt mode and when enabled
  assign mon.supply_irq = supply_low_in &&
    mon_q[pmu_regs_pkg::MON_RESP_BIT] &&
    mon_q[pmu_regs_pkg::MON_IEN_BIT];
  assign mon.auto_shutdown = supply_low_in &&
    !mon_q[pmu_regs_pkg::MON_RESP_BIT];

  // Buck1 controls; force-on overrides only while hibernating
  assign buck.enable = ctl_q[pmu_regs_pkg::CTL_ON_BIT] ||
    (hibernate_in && hib_q[pmu_regs_pkg::HIB_FRC_BIT]);
  assign buck.phase_shift = ctl_q[pmu_regs_pkg::CTL_PHASE_BIT];
  assign buck.forced_pwm = ctl_q[pmu_regs_pkg::CTL_MODE_BIT];
  assign buck.turn_on_delay = ctl_q[pmu_regs_pkg::CTL_DLY_LSB +: 3];
  assign buck.voltage_code = voltage_select_pin_in ? sec_q : pri_q;
  assign buck.fault_irq = buck1_fault_in &&
    ctl_q[pmu_regs_pkg::CTL_FIEN_BIT];

  assign reset_timeout_sel_out = mon.reset_timeout_sel;
  assign supply_threshold_code_out = mon.supply_threshold_code;
  assign supply_irq_out = mon.supply_irq;
  assign auto_shutdown_out = mon.auto_shutdown;
  assign buck1_enable_out = buck.enable;
  assign buck1_phase_out = buck.phase_shift;
  assign buck1_forced_pwm_out = buck.forced_pwm;
  assign buck1_delay_out = buck.turn_on_delay;
  assign buck1_vcode_out = buck.voltage_code;
  assign buck1_fault_irq_out = buck.fault_irq;

endmodule

`default_nettype wire

// ===== dv/pmu_regs_properties.sv
// Port-level properties of the PMU control bank
`timescale 1ns/1ps
`default_nettype none
module pmu_regs_properties (
  // Clock, reset, register port
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // Events and outputs
  input wire logic supply_low_in,
  input wire logic buck1_fault_in,
  input wire logic supply_irq_out,
  input wire logic auto_shutdown_out,
  input wire logic [3:0] supply_threshold_code_out,
  input wire logic [2:0] buck1_delay_out,
  input wire logic buck1_fault_irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  irq_low_a: assert property (supply_irq_out |-> supply_low_in)
    else $error("supply irq without low supply");
  auto_low_a: assert property (auto_shutdown_out |->
    supply_low_in && !supply_irq_out) else $error("bad shutdown");
  fault_gate_a: assert property (buck1_fault_irq_out |->
    buck1_fault_in) else $error("fault irq without fault");
  rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (rd_in && !(addr_in inside
    {8'h00, 8'h01, 8'h20, 8'h21, 8'h22}) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  status_rd_a: assert property (rd_in && addr_in == 8'h00 |=>
    rdata_out[4] == $past(supply_low_in)) else $error("bad status");
  delay_wr_a: assert property (wr_in && addr_in == 8'h22 |=>
    buck1_delay_out == $past(wdata_in[4:2])) else $error("bad delay");
  thr_wr_a: assert property (wr_in && addr_in == 8'h00 |=>
    supply_threshold_code_out == $past(wdata_in[3:0]))
    else $error("bad threshold");
endmodule
bind pmu_system_and_buck_control_regs pmu_regs_properties chk_u (
  .core_clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .supply_low_in, .buck1_fault_in, .supply_irq_out, .auto_shutdown_out,
  .supply_threshold_code_out, .buck1_delay_out, .buck1_fault_irq_out);
`default_nettype wire

// ===== dv/test_pmu_system_and_buck_control_regs.sv
// Register sequence test of the PMU control bank
`timescale 1ns/1ps
`default_nettype none
module test_pmu_system_and_buck_control_regs;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic low = 1'b0, shut = 1'b0, hib = 1'b0, flt = 1'b0, voltage_select_pin = 1'b0;
  logic trst, irq, asd, en, ph, pwm, firq;
  logic [3:0] thr;
  logic [2:0] dly;
  logic [5:0] vc;
  int n_mismatch = 0, num_checks = 0;
  logic [7:0] offs [5] = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h22};
  always #50 clk = ~clk;
  pmu_system_and_buck_control_regs dut_u (.core_clk_in(clk),
    .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .supply_low_in(low),
    .system_shutdown_in(shut), .hibernate_in(hib), .buck1_fault_in(flt),
    .voltage_select_pin_in(voltage_select_pin), .reset_timeout_sel_out(trst),
    .supply_threshold_code_out(thr), .supply_irq_out(irq),
    .auto_shutdown_out(asd), .buck1_enable_out(en), .buck1_phase_out(ph),
    .buck1_forced_pwm_out(pwm), .buck1_delay_out(dly),
    .buck1_vcode_out(vc), .buck1_fault_irq_out(firq));
  task automatic chk(string what, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  task automatic zero_check();
    foreach (offs[i]) rd_reg(offs[i], 8'h00);
    rd_reg(8'h10, 8'h00);
    $display("test reset values done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    zero_check();
    wr_reg(8'h00, 8'hff);
    rd_reg(8'h00, 8'hef);
    chk("mon", {trst, 3'h0, thr}, 8'h8f);
    @(posedge clk) low <= 1'b1;
    #1 chk("irq", {6'h00, irq, asd}, 8'h02);
    rd_reg(8'h00, 8'hff);
    wr_reg(8'h00, 8'h8f);
    chk("irq", {6'h00, irq, asd}, 8'h01);
    wr_reg(8'h00, 8'h40);
    chk("irq", {6'h00, irq, asd}, 8'h00);
    rd_reg(8'h00, 8'h50);
    wr_reg(8'h10, 8'hff);
    rd_reg(8'h10, 8'h00);
    $display("test monitor done");
    // Force-on set before entering hibernate
    wr_reg(8'h01, 8'hff);
    rd_reg(8'h01, 8'h4f);
    @(posedge clk) hib <= 1'b1;
    #1 chk("en", {7'h00, en}, 8'h01);
    @(posedge clk) shut <= 1'b1;
    @(posedge clk) shut <= 1'b0;
    rd_reg(8'h01, 8'h42);
    wr_reg(8'h01, 8'h02);
    chk("en", {7'h00, en}, 8'h00);
    @(posedge clk) hib <= 1'b0;
    $display("test hibernate done");
    wr_reg(8'h20, 8'hff);
    wr_reg(8'h21, 8'h15);
    rd_reg(8'h20, 8'h3f);
    chk("vcode", {2'h0, vc}, 8'h3f);
    @(posedge clk) voltage_select_pin <= 1'b1;
    #1 chk("vcode", {2'h0, vc}, 8'h15);
    wr_reg(8'h22, 8'hff);
    rd_reg(8'h22, 8'hfe);
    chk("buck", {en, ph, pwm, dly, 2'h0}, 8'hfc);
    @(posedge clk) flt <= 1'b1;
    #1 chk("firq", {7'h00, firq}, 8'h01);
    wr_reg(8'h22, 8'h1c);
    chk("buck", {en, ph, pwm, dly, firq, 1'b0}, 8'h1c);
    $display("test buck done");
    // Reset in mid-run stands for a power loss
    // Live inputs back to idle so the status bit reads its default
    @(posedge clk) {rst_n, low, flt, voltage_select_pin} <= 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    zero_check();
    summarize();
  end
endmodule
`default_nettype wire
